/* File: src/hint_cfg_pkg.sv */
package hint_cfg_pkg;

	// ==========================================================
	// Register page
	localparam logic [11:0] OFS_FEATURE_ENABLE = 12'h820;
	localparam logic [11:0] OFS_READ_PREFETCH_HINTS = 12'h824;
	localparam logic [11:0] OFS_WRITE_SPLIT_HINTS = 12'h828;
	localparam int PAGE_OFS_W = 12;
	localparam int BUS_ID_W = 10;
	localparam int SLOT_W = 4;
	localparam int SUBMOD_W = 2;

	// ==========================================================
	// Reset values and field layout
	localparam logic [31:0] FEATURE_ENABLE_RST = 32'h0000_0000;
	localparam logic [3:0] READ_HINT_RST = 4'h0;
	localparam logic [1:0] WRITE_HINT_RST = 2'h0;
	localparam int NUM_MASTERS = 6;
	localparam int READ_HINT_W = 4;
	localparam int WRITE_HINT_W = 2;
	localparam int WRITE_HINT_STRIDE = 4;

	// Feature enable bit positions
	localparam int FEAT_RD_LINE_BIT = 0;
	localparam int FEAT_RD_MULT_BIT = 1;
	localparam int FEAT_MWI_BIT = 2;
	localparam int FEAT_LONG_BIT = 3;

	// ==========================================================
	// Read hint encodings
	localparam logic [3:0] RH_WORDS_1 = 4'h0;
	localparam logic [3:0] RH_WORDS_2 = 4'h1;
	localparam logic [3:0] RH_WORDS_4 = 4'h2;
	localparam logic [3:0] RH_WORDS_8 = 4'h3;
	localparam logic [3:0] RH_WORDS_16 = 4'h4;
	localparam logic [3:0] RH_WORDS_24 = 4'h5;
	localparam logic [3:0] RH_HALF_FULL = 4'hb;
	localparam logic [3:0] RH_FULL = 4'hf;

	// Write split encoding forced by write-and-invalidate
	localparam logic [1:0] WH_EIGHT = 2'h3;

	// PCI bus commands
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
	localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
	localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hf;

	typedef enum logic [1:0] {
		FILL_FIXED,
		FILL_HALF,
		FILL_FULL
	} fill_mode_e;

endpackage

/* File: src/read_hint_decode.sv */
`timescale 1ns/1ps
module read_hint_decode
	import hint_cfg_pkg::*;
(
	input wire logic [3:0] hint_i,
	input wire logic long_en_i,
	output logic [4:0] words_o,
	output fill_mode_e mode_o,
	output logic long_o
);

	// Unlisted codes fall back to single word, the safest prefetch
	always_comb begin
		words_o = 5'h01;
		mode_o = FILL_FIXED;
		long_o = 1'b0;
		unique case (hint_i)
			RH_WORDS_2: words_o = 5'h02;
			RH_WORDS_4: words_o = 5'h04;
			RH_WORDS_8: words_o = 5'h08;
			RH_WORDS_16: begin
				words_o = 5'h10;
				long_o = long_en_i;
			end
			RH_WORDS_24: begin
				words_o = 5'h18;
				long_o = long_en_i;
			end
			RH_HALF_FULL: begin
				mode_o = FILL_HALF;
				long_o = long_en_i;
			end
			RH_FULL: begin
				mode_o = FILL_FULL;
				long_o = long_en_i;
			end
			default: words_o = 5'h01;
		endcase
	end

endmodule

/* File: src/bridge_transfer_hint_config.sv */
`timescale 1ns/1ps
// Contract
// - Take broadcast bus id, store 10 bits, then answer page accesses.
// - Match address to 4K page from bus id, slot, submodule before access.
// - Bus id decodes only the register page, never forwarding.
// - Software programs bus id first; block stays inactive until then.
// - Separate read and write hint per each of six masters, by owner.
// - Read hints six 4-bit fields at 3:0..23:20, 31:24 unused, reset zero.
// - Codes 0..5 prefetch 1,2,4,8,16,24 words; long only for 16, 24.
// - Code b half-full, code f full, both assert long when enabled.
// - Read size toward system bus comes from owning master's read hint.
// - Enabled read line acts as code 5, 24 words.
// - Enabled read multiple acts as code f, keep buffer full.
// - Write split hints register, read/write, at 0x828.
// - Read prefetch hints register, read/write, at 0x824.
// - Feature enable register, read/write, at 0x820.
// - Write hint 0 single, 1 double, 2 quad, 3 eight-word pieces.
// - Enabled write-and-invalidate forces eight-word writes.
module bridge_transfer_hint_config
	import hint_cfg_pkg::*;
#(
	parameter logic [3:0] PAGE_TOP = 4'hf
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic bcast_valid_i,
	input wire logic [BUS_ID_W-1:0] bcast_id_i,
	input wire logic [SLOT_W-1:0] slot_i,
	input wire logic [SUBMOD_W-1:0] submod_i,
	input wire logic sys_valid_i,
	input wire logic sys_write_i,
	input wire logic [31:0] sys_addr_i,
	input wire logic [31:0] sys_wdata_i,
	output logic sys_ack_o,
	output logic [31:0] sys_rdata_o,
	output logic active_o,
	input wire logic txn_start_i,
	input wire logic [2:0] txn_master_i,
	input wire logic [3:0] txn_cmd_i,
	input wire logic txn_done_i,
	output logic hint_valid_o,
	output logic [4:0] read_words_o,
	output fill_mode_e fill_mode_o,
	output logic long_transfer_indication_o,
	output logic [1:0] write_piece_o
);

	// ==========================================================
	// Bus identification and page decode
	logic programmed;
	logic [BUS_ID_W-1:0] bus_id;
	logic page_hit;
	logic [PAGE_OFS_W-1:0] ofs;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			programmed <= 1'b0;
			bus_id <= '0;
		end else if (bcast_valid_i) begin
			programmed <= 1'b1;
			bus_id <= bcast_id_i;
		end
	end

	// Bus id only feeds this compare; nothing here steers forwarding
	assign page_hit = programmed && sys_addr_i[31:28] == PAGE_TOP
		&& sys_addr_i[27:12] == {bus_id, slot_i, submod_i};
	assign ofs = sys_addr_i[PAGE_OFS_W-1:0];
	assign active_o = programmed;

	// ==========================================================
	// Registers
	logic [31:0] feature_enable;
	logic [READ_HINT_W-1:0] read_hint [NUM_MASTERS];
	logic [WRITE_HINT_W-1:0] write_hint [NUM_MASTERS];
	logic [31:0] read_prefetch_hints;
	logic [31:0] write_split_hints;
	logic wr_en;

	assign wr_en = sys_valid_i && sys_write_i && page_hit;

	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			feature_enable <= FEATURE_ENABLE_RST;
		else if (wr_en && ofs == OFS_FEATURE_ENABLE)
			feature_enable <= sys_wdata_i;
	end

	genvar m;
	generate
		for (m = 0; m < NUM_MASTERS; m++) begin : g_hint
			always_ff @(posedge clk_i) begin
				if (!rstn_i)
					read_hint[m] <= READ_HINT_RST;
				else if (wr_en && ofs == OFS_READ_PREFETCH_HINTS)
					read_hint[m] <= sys_wdata_i[m*READ_HINT_W +: READ_HINT_W];
			end
			always_ff @(posedge clk_i) begin
				if (!rstn_i)
					write_hint[m] <= WRITE_HINT_RST;
				else if (wr_en && ofs == OFS_WRITE_SPLIT_HINTS)
					write_hint[m] <= sys_wdata_i[m*WRITE_HINT_STRIDE +: WRITE_HINT_W];
			end
			assign read_prefetch_hints[m*READ_HINT_W +: READ_HINT_W] = read_hint[m];
			assign write_split_hints[m*WRITE_HINT_STRIDE +: WRITE_HINT_STRIDE] =
				{2'h0, write_hint[m]};
		end
	endgenerate
	// Spare bits read as zero
	assign read_prefetch_hints[31:24] = 8'h00;
	assign write_split_hints[31:24] = 8'h00;

	// Every matched access is answered; unknown offsets read zero
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sys_ack_o <= 1'b0;
			sys_rdata_o <= 32'h0000_0000;
		end else begin
			sys_ack_o <= sys_valid_i && page_hit;
			if (sys_valid_i && page_hit && !sys_write_i) begin
				unique case (ofs)
					OFS_FEATURE_ENABLE: sys_rdata_o <= feature_enable;
					OFS_READ_PREFETCH_HINTS: sys_rdata_o <= read_prefetch_hints;
					OFS_WRITE_SPLIT_HINTS: sys_rdata_o <= write_split_hints;
					default: sys_rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// Hint selection per transaction
	logic [3:0] sel_read;
	logic [1:0] sel_write;
	logic [3:0] eff_read;
	logic [1:0] eff_write;
	logic [4:0] dec_words;
	fill_mode_e dec_mode;
	logic dec_long;

	always_comb begin
		sel_read = READ_HINT_RST;
		sel_write = WRITE_HINT_RST;
		if (txn_master_i < 3'(NUM_MASTERS)) begin
			sel_read = read_hint[txn_master_i];
			sel_write = write_hint[txn_master_i];
		end
		eff_read = sel_read;
		if (feature_enable[FEAT_RD_LINE_BIT] && txn_cmd_i == CMD_MEM_READ_LINE)
			eff_read = RH_WORDS_24;
		else if (feature_enable[FEAT_RD_MULT_BIT] && txn_cmd_i == CMD_MEM_READ_MULT)
			eff_read = RH_FULL;
		eff_write = sel_write;
		if (feature_enable[FEAT_MWI_BIT] && txn_cmd_i == CMD_MEM_WRITE_INV)
			eff_write = WH_EIGHT;
	end

	read_hint_decode u_decode (
		.hint_i(eff_read),
		.long_en_i(feature_enable[FEAT_LONG_BIT]),
		.words_o(dec_words),
		.mode_o(dec_mode),
		.long_o(dec_long)
	);

	// A start while a transaction is open is ignored; the open one keeps its hint
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			hint_valid_o <= 1'b0;
			read_words_o <= 5'h01;
			fill_mode_o <= FILL_FIXED;
			long_transfer_indication_o <= 1'b0;
			write_piece_o <= 2'h0;
		end else if (!hint_valid_o && txn_start_i && programmed) begin
			hint_valid_o <= 1'b1;
			read_words_o <= dec_words;
			fill_mode_o <= dec_mode;
			long_transfer_indication_o <= dec_long;
			write_piece_o <= eff_write;
		end else if (hint_valid_o && txn_done_i) begin
			hint_valid_o <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	property p_silent_unprog;
		@(posedge clk_i) disable iff (!rstn_i)
		sys_valid_i && !programmed |=> !sys_ack_o;
	endproperty
	a_silent_unprog: assert property (p_silent_unprog) else $error("ack before bus id");

	property p_ack_hit;
		@(posedge clk_i) disable iff (!rstn_i)
		sys_valid_i && programmed && sys_addr_i[27:12] == {bus_id, slot_i, submod_i}
			&& sys_addr_i[31:28] == PAGE_TOP |=> sys_ack_o;
	endproperty
	a_ack_hit: assert property (p_ack_hit) else $error("page hit not acked");

	property p_no_ack_miss;
		@(posedge clk_i) disable iff (!rstn_i)
		sys_valid_i && sys_addr_i[27:18] != bus_id |=> !sys_ack_o;
	endproperty
	a_no_ack_miss: assert property (p_no_ack_miss) else $error("ack on miss");

	property p_bcast;
		@(posedge clk_i) disable iff (!rstn_i)
		bcast_valid_i |=> active_o && bus_id == $past(bcast_id_i);
	endproperty
	a_bcast: assert property (p_bcast) else $error("bus id not stored");

	property p_rd_reset;
		@(posedge clk_i) !rstn_i |=> read_prefetch_hints == 32'h0000_0000;
	endproperty
	a_rd_reset: assert property (p_rd_reset) else $error("read hints not reset");

	property p_rd_line;
		@(posedge clk_i) disable iff (!rstn_i)
		!hint_valid_o && txn_start_i && programmed && feature_enable[FEAT_RD_LINE_BIT]
			&& txn_cmd_i == CMD_MEM_READ_LINE |=> read_words_o == 5'h18 && fill_mode_o == FILL_FIXED;
	endproperty
	a_rd_line: assert property (p_rd_line) else $error("read line not 24 words");

	property p_rd_mult;
		@(posedge clk_i) disable iff (!rstn_i)
		!hint_valid_o && txn_start_i && programmed && feature_enable[FEAT_RD_MULT_BIT]
			&& txn_cmd_i == CMD_MEM_READ_MULT |=> fill_mode_o == FILL_FULL;
	endproperty
	a_rd_mult: assert property (p_rd_mult) else $error("read multiple not full");

	property p_mwi;
		@(posedge clk_i) disable iff (!rstn_i)
		!hint_valid_o && txn_start_i && programmed && feature_enable[FEAT_MWI_BIT]
			&& txn_cmd_i == CMD_MEM_WRITE_INV |=> write_piece_o == WH_EIGHT;
	endproperty
	a_mwi: assert property (p_mwi) else $error("invalidate write not eight");

	property p_hold;
		@(posedge clk_i) disable iff (!rstn_i)
		hint_valid_o && !txn_done_i |=> hint_valid_o && $stable(read_words_o)
			&& $stable(write_piece_o) && $stable(fill_mode_o);
	endproperty
	a_hold: assert property (p_hold) else $error("hint changed mid transaction");

	property p_long;
		@(posedge clk_i) disable iff (!rstn_i)
		long_transfer_indication_o |-> read_words_o >= 5'h10 || fill_mode_o != FILL_FIXED;
	endproperty
	a_long: assert property (p_long) else $error("long on short prefetch");

endmodule

/* File: tb/pci_master_model.sv */
`timescale 1ns/1ps
// ==========================================================
// PCI master side: one owner at a time, start then done
module pci_master_model (
	input wire logic clk_i,
	output logic txn_start_o,
	output logic [2:0] txn_master_o,
	output logic [3:0] txn_cmd_o,
	output logic txn_done_o
);
	initial begin
		txn_start_o = 1'b0;
		txn_master_o = 3'h0;
		txn_cmd_o = 4'h0;
		txn_done_o = 1'b0;
	end

	// Owner and command qualify only the start edge; inverted after so stale values cannot pass
	task automatic start(input logic [2:0] m, input logic [3:0] c);
		@(posedge clk_i);
		txn_start_o <= 1'b1;
		txn_master_o <= m;
		txn_cmd_o <= c;
		@(posedge clk_i);
		txn_start_o <= 1'b0;
		txn_master_o <= ~m;
		txn_cmd_o <= ~c;
	endtask

	task automatic finish();
		@(posedge clk_i);
		txn_done_o <= 1'b1;
		@(posedge clk_i);
		txn_done_o <= 1'b0;
	endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import hint_cfg_pkg::*;
	localparam logic [9:0] ID = 10'h2a5;
	localparam logic [31:0] BASE = {4'hf, ID, 4'h9, 2'h2, 12'h000};
	logic clk_i, rstn_i, bcast_valid_i, sys_valid_i, sys_write_i, sys_ack_o, active_o;
	logic [9:0] bcast_id_i;
	logic [31:0] sys_addr_i, sys_wdata_i, sys_rdata_o, rh;
	logic txn_start_i, txn_done_i, hint_valid_o, long_transfer_indication_o;
	logic [2:0] txn_master_i;
	logic [3:0] txn_cmd_i, c;
	logic [4:0] read_words_o;
	logic [1:0] write_piece_o;
	fill_mode_e fill_mode_o;
	int fail_count = 0;
	int n_tests = 0;
	logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hb, 4'hf, 4'h7, 4'hc};
	int pos [4] = '{12, 14, 18, 28};

	// ==========================================================
	// Clock, design, far side
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	bridge_transfer_hint_config dut (.clk_i(clk_i), .rstn_i(rstn_i),
		.bcast_valid_i(bcast_valid_i), .bcast_id_i(bcast_id_i), .slot_i(4'h9), .submod_i(2'h2),
		.sys_valid_i(sys_valid_i), .sys_write_i(sys_write_i), .sys_addr_i(sys_addr_i),
		.sys_wdata_i(sys_wdata_i), .sys_ack_o(sys_ack_o), .sys_rdata_o(sys_rdata_o),
		.active_o(active_o), .txn_start_i(txn_start_i), .txn_master_i(txn_master_i),
		.txn_cmd_i(txn_cmd_i), .txn_done_i(txn_done_i), .hint_valid_o(hint_valid_o),
		.read_words_o(read_words_o), .fill_mode_o(fill_mode_o),
		.long_transfer_indication_o(long_transfer_indication_o), .write_piece_o(write_piece_o));
	pci_master_model pm (.clk_i(clk_i), .txn_start_o(txn_start_i), .txn_master_o(txn_master_i),
		.txn_cmd_o(txn_cmd_i), .txn_done_o(txn_done_i));

	// ==========================================================
	// Checks and access tasks
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", name, e, g);
			fail_count++;
		end
	endtask

	// Expected {words, mode, long}; reserved codes fall back to one word
	function automatic logic [7:0] rexp(input logic [3:0] k, input logic le);
		logic [4:0] w;
		fill_mode_e md;
		w = (k <= 4'h4) ? (5'h01 << k) : 5'h01;
		w = (k == 4'h5) ? 5'h18 : w;
		md = (k == 4'hb) ? FILL_HALF : ((k == 4'hf) ? FILL_FULL : FILL_FIXED);
		return {w, md, le && (k == 4'h4 || k == 4'h5 || k == 4'hb || k == 4'hf)};
	endfunction

	task automatic acc(input logic w, input logic [31:0] a, d, input logic ak, input logic [31:0] e);
		@(posedge clk_i);
		sys_valid_i <= 1'b1;
		sys_write_i <= w;
		sys_addr_i <= a;
		sys_wdata_i <= d;
		@(posedge clk_i);
		sys_valid_i <= 1'b0;
		sys_addr_i <= ~a;
		sys_wdata_i <= ~d;
		#1 chk("ack", ak, sys_ack_o);
		if (!w && ak) chk("rdata", e, sys_rdata_o);
	endtask

	task automatic tchk(input logic [3:0] cmd, input logic [7:0] e);
		#1 chk("hint_valid", 1'b1, hint_valid_o);
		if (cmd[0]) chk("piece", e, write_piece_o);
		else chk("read_hint", e, {read_words_o, fill_mode_o, long_transfer_indication_o});
	endtask

	task automatic txn(input logic [2:0] m, input logic [3:0] cmd, input logic [7:0] e);
		pm.start(m, cmd);
		tchk(cmd, e);
		pm.finish();
		#1 chk("hint_valid", 1'b0, hint_valid_o);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge clk_i);
		fail_count++;
		results();
	end

	// ==========================================================
	// Tests
	initial begin
		{rstn_i, bcast_valid_i, sys_valid_i, sys_write_i} = 4'h0;
		{bcast_id_i, sys_addr_i, sys_wdata_i} = '0;
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		#1 chk("reset", {5'h01, FILL_FIXED, 3'h0},
			{read_words_o, fill_mode_o, active_o, hint_valid_o, long_transfer_indication_o});
		acc(1'b0, BASE | OFS_READ_PREFETCH_HINTS, 32'h0, 1'b0, 32'h0);
		pm.start(3'h0, CMD_MEM_READ);
		#1 chk("idle_txn", 1'b0, hint_valid_o);
		pm.finish();
		@(posedge clk_i);
		bcast_valid_i <= 1'b1;
		bcast_id_i <= ID;
		@(posedge clk_i);
		bcast_valid_i <= 1'b0;
		bcast_id_i <= ~ID;
		#1 chk("active", 1'b1, active_o);
		acc(1'b0, BASE | OFS_FEATURE_ENABLE, 32'h0, 1'b1, 32'h0);
		acc(1'b0, BASE | OFS_READ_PREFETCH_HINTS, 32'h0, 1'b1, 32'h0);
		acc(1'b0, BASE | OFS_WRITE_SPLIT_HINTS, 32'h0, 1'b1, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rh = (BASE | OFS_READ_PREFETCH_HINTS) ^ (32'h1 << pos[i]);
			acc(1'b1, rh, 32'hffff_ffff, 1'b0, 32'h0);
		end
		acc(1'b0, BASE | OFS_READ_PREFETCH_HINTS, 32'h0, 1'b1, 32'h0);
		acc(1'b1, BASE | OFS_FEATURE_ENABLE, 32'ha5a5_a5a5, 1'b1, 32'h0);
		acc(1'b0, BASE | OFS_FEATURE_ENABLE, 32'h0, 1'b1, 32'ha5a5_a5a5);
		acc(1'b1, BASE | OFS_WRITE_SPLIT_HINTS, 32'hffff_ffff, 1'b1, 32'h0);
		acc(1'b0, BASE | OFS_WRITE_SPLIT_HINTS, 32'h0, 1'b1, 32'h0033_3333);
		acc(1'b0, BASE | 32'h82c, 32'h0, 1'b1, 32'h0);
		for (int le = 0; le < 2; le++) begin
			acc(1'b1, BASE | OFS_FEATURE_ENABLE, le ? 32'h8 : 32'h0, 1'b1, 32'h0);
			for (int i = 0; i < 10; i++) begin
				c = codes[i];
				rh = (32'h0033_3333 & ~(32'hf << (4 * (i % 6)))) | ({28'h0, c} << (4 * (i % 6)));
				acc(1'b1, BASE | OFS_READ_PREFETCH_HINTS, rh, 1'b1, 32'h0);
				acc(1'b0, BASE | OFS_READ_PREFETCH_HINTS, 32'h0, 1'b1, rh);
				txn(3'(i % 6), CMD_MEM_READ, rexp(c, le[0]));
			end
		end
		// Owners beyond the six masters fall back to the reset hints
		txn(3'h6, CMD_MEM_READ, rexp(4'h0, 1'b1));
		for (int p = 0; p < 4; p++) begin
			rh = (32'h0033_3333 & ~(32'h3 << (4 * (p + 2)))) | (32'(p) << (4 * (p + 2)));
			acc(1'b1, BASE | OFS_WRITE_SPLIT_HINTS, rh, 1'b1, 32'h0);
			txn(3'(p + 2), CMD_MEM_WRITE, 8'(p));
		end
		txn(3'h7, CMD_MEM_WRITE, 8'h0);
		acc(1'b1, BASE | OFS_READ_PREFETCH_HINTS, 32'h0, 1'b1, 32'h0);
		acc(1'b1, BASE | OFS_WRITE_SPLIT_HINTS, 32'h0, 1'b1, 32'h0);
		acc(1'b1, BASE | OFS_FEATURE_ENABLE, 32'h0, 1'b1, 32'h0);
		txn(3'h1, CMD_MEM_READ_LINE, rexp(4'h0, 1'b0));
		txn(3'h1, CMD_MEM_READ_MULT, rexp(4'h0, 1'b0));
		txn(3'h1, CMD_MEM_WRITE_INV, 8'h0);
		acc(1'b1, BASE | OFS_FEATURE_ENABLE, 32'hf, 1'b1, 32'h0);
		txn(3'h1, CMD_MEM_READ_LINE, rexp(4'h5, 1'b1));
		txn(3'h1, CMD_MEM_READ_MULT, rexp(4'hf, 1'b1));
		txn(3'h1, CMD_MEM_WRITE_INV, 8'h3);
		acc(1'b1, BASE | OFS_READ_PREFETCH_HINTS, 32'h4, 1'b1, 32'h0);
		pm.start(3'h0, CMD_MEM_READ);
		tchk(CMD_MEM_READ, rexp(4'h4, 1'b1));
		acc(1'b1, BASE | OFS_READ_PREFETCH_HINTS, 32'h0, 1'b1, 32'h0);
		pm.start(3'h0, CMD_MEM_READ_MULT);
		tchk(CMD_MEM_READ, rexp(4'h4, 1'b1));
		pm.finish();
		#1 chk("hint_valid", 1'b0, hint_valid_o);
		results();
	end
endmodule
